// ---- debug_chip_erase_core_hold.sv ----
// Debug access logic: core hold at reset release, chip erase, test port enable
module debug_chip_erase_core_hold (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ext_reset_n_pin,
  input  wire logic        test_clk_pin,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        protect_set_cmd,
  input  wire logic        volatile_clear_ack,
  input  wire logic        flash_clear_ack,
  output logic             volatile_clear_req,
  output logic             flash_clear_req,
  output logic             flash_keep_user_page,
  output logic             core_reset,
  output logic             system_reset,
  output logic             debug_port_reset,
  output logic             slow_clock_select,
  output logic             test_port_enable,
  output logic             protected_state,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detect

  logic [1:0] pin_s;
  logic       ext_held;
  logic       tck_s;
  logic       ext_held_q;
  logic       tck_q;
  logic       ext_release;
  logic       ext_assert;
  logic       tck_fall;

  pin_sync #(
    .WIDTH (2),
    .RST   (erase_pkg::PIN_SYNC_RST)
  ) u_pin_sync (
    .clk    (clk),
    .reset  (reset),
    .pin_in ({test_clk_pin, ext_reset_n_pin}),
    .pin_s  (pin_s)
  );

  assign ext_held = ~pin_s[0];
  assign tck_s    = pin_s[1];

  always_ff @(posedge clk) begin
    if (reset) begin
      ext_held_q <= 1'b1;
      tck_q      <= 1'b1;
    end else begin
      ext_held_q <= ext_held;
      tck_q      <= tck_s;
    end
  end

  assign ext_release = ext_held_q & ~ext_held;
  assign ext_assert  = ~ext_held_q & ext_held;
  assign tck_fall    = tck_q & ~tck_s;

  ////////////////////////////////////////////////////////////////////////////
  // Register decode

  logic wr_ctrl;
  logic wr_cmd;
  logic wr_sys;
  logic wr_mask;
  logic rd_irq;
  logic erase_go;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  assign wr_ctrl = reg_wr & hit(reg_addr, erase_pkg::CTRL_OFS);
  assign wr_cmd  = reg_wr & hit(reg_addr, erase_pkg::CMD_OFS);
  assign wr_sys  = reg_wr & hit(reg_addr, erase_pkg::SYSCTRL_OFS);
  assign wr_mask = reg_wr & hit(reg_addr, erase_pkg::IRQ_MASK_OFS);
  assign rd_irq  = reg_rd & hit(reg_addr, erase_pkg::IRQ_STAT_OFS);

  ////////////////////////////////////////////////////////////////////////////
  // Erase sequencer

  erase_if eif ();

  // A second start while busy is dropped; the running erase owns memories
  assign erase_go = ~eif.busy &
                    ((wr_ctrl & reg_wdata[erase_pkg::CTRL_CE_BIT]) |
                     (wr_cmd & (reg_wdata[7:0] == erase_pkg::ERASE_CMD)));
  assign eif.start = erase_go;

  erase_seq u_erase_seq (
    .clk                (clk),
    .reset              (reset),
    .ctl                (eif.seq),
    .volatile_clear_ack (volatile_clear_ack),
    .flash_clear_ack    (flash_clear_ack),
    .volatile_clear_req (volatile_clear_req),
    .flash_clear_req    (flash_clear_req)
  );

  // Erase never reaches the user page
  assign flash_keep_user_page = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Core hold, resets and clock select

  logic core_hold_q;
  logic slow_sel_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      core_hold_q <= 1'b0;
    end else if (ext_release) begin
      core_hold_q <= ~tck_s;
    end else if (wr_sys & reg_wdata[erase_pkg::SYS_HOLD_CLR_BIT]) begin
      core_hold_q <= 1'b0;
    end
  end

  // Power manager is running once this logic is out of its own reset
  always_ff @(posedge clk) begin
    if (reset) begin
      slow_sel_q <= 1'b0;
    end else begin
      slow_sel_q <= 1'b1;
    end
  end

  assign slow_clock_select = slow_sel_q;
  assign system_reset      = ext_held;
  assign core_reset        = ext_held | core_hold_q;
  // Debug side sees only its own reset, never the pin
  assign debug_port_reset  = reset;

  ////////////////////////////////////////////////////////////////////////////
  // Test port enable

  logic tp_en_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      tp_en_q <= 1'b0;
    end else if (ext_held) begin
      tp_en_q <= 1'b0;
    end else if (ext_release & tck_s) begin
      tp_en_q <= 1'b0;
    end else if (tck_fall) begin
      tp_en_q <= 1'b1;
    end
  end

  assign test_port_enable = tp_en_q;

  ////////////////////////////////////////////////////////////////////////////
  // Protected state

  logic prot_q;
  logic prot_pend_q;

  // New protection waits for a chip reset; erase clears both
  always_ff @(posedge clk) begin
    if (reset) begin
      prot_q      <= 1'b0;
      prot_pend_q <= 1'b0;
    end else if (eif.prot_clear) begin
      prot_q      <= 1'b0;
      prot_pend_q <= 1'b0;
    end else if (ext_release) begin
      prot_q      <= prot_q | prot_pend_q;
      prot_pend_q <= 1'b0;
    end else if (protect_set_cmd) begin
      prot_pend_q <= 1'b1;
    end
  end

  assign protected_state = prot_q;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupts

  logic [erase_pkg::IRQ_W-1:0] ev;
  logic [erase_pkg::IRQ_W-1:0] irq_stat_q;
  logic [erase_pkg::IRQ_W-1:0] irq_mask_q;
  logic                        done_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      done_q <= 1'b0;
    end else begin
      done_q <= eif.done;
    end
  end

  assign ev[erase_pkg::EV_DONE_BIT] = eif.done & ~done_q;
  assign ev[erase_pkg::EV_TPEN_BIT] = ~ext_held & ~(ext_release & tck_s) & tck_fall & ~tp_en_q;

  // Set wins over the clear of a read in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_stat_q <= '0;
    end else if (rd_irq) begin
      irq_stat_q <= ev;
    end else begin
      irq_stat_q <= irq_stat_q | ev;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_mask_q <= erase_pkg::IRQ_MASK_RST;
    end else if (wr_mask) begin
      irq_mask_q <= reg_wdata[erase_pkg::IRQ_W-1:0];
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  logic [31:0] status;

  always_comb begin
    status                         = '0;
    status[erase_pkg::ST_DONE_BIT] = eif.done;
    status[erase_pkg::ST_HOLD_BIT] = core_hold_q;
    status[erase_pkg::ST_BUSY_BIT] = eif.busy;
    status[erase_pkg::ST_PROT_BIT] = prot_q;
    status[erase_pkg::ST_TPEN_BIT] = tp_en_q;
    status[erase_pkg::ST_PEND_BIT] = prot_pend_q;
  end

  // Unmapped and write-only words read zero
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        erase_pkg::STATUS_OFS:   reg_rdata <= status;
        erase_pkg::SYSCTRL_OFS:  reg_rdata <= {31'h0, core_hold_q};
        erase_pkg::IRQ_STAT_OFS: reg_rdata <= {30'h0, irq_stat_q};
        erase_pkg::IRQ_MASK_OFS: reg_rdata <= {30'h0, irq_mask_q};
        default:                 reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // Checks use synced pin levels; raw pins lead them by two edges

  erase_start_a: assert property (erase_go && wr_ctrl |=> volatile_clear_req)
    else $error("control write did not start erase");
  cmd_start_a: assert property (wr_cmd && reg_wdata[7:0] == erase_pkg::ERASE_CMD && !eif.busy
    |=> eif.busy && volatile_clear_req)
    else $error("erase command did not start erase");
  vol_first_a: assert property ($rose(flash_clear_req) |-> $past(volatile_clear_req))
    else $error("flash cleared before volatile memories");
  prot_last_a: assert property (eif.prot_clear |-> $past(flash_clear_req && flash_clear_ack))
    else $error("protected state cleared out of order");
  prot_cleared_a: assert property (eif.prot_clear |=> !protected_state)
    else $error("protected state survived erase");
  user_page_a: assert property (flash_clear_req |-> flash_keep_user_page)
    else $error("user page not kept");
  done_rise_a: assert property ($rose(eif.done) |-> $past(eif.prot_clear))
    else $error("done rose before final step");
  done_low_a: assert property (eif.busy |-> !eif.done)
    else $error("done high during erase");
  vol_alone_a: assert property (volatile_clear_req |-> eif.busy && !flash_clear_req)
    else $error("volatile step overlaps a later step");
  done_irq_a: assert property ($rose(eif.done) |=> irq_stat_q[erase_pkg::EV_DONE_BIT])
    else $error("erase done event not latched");
  rd_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  hold_set_a: assert property (ext_release && !tck_s |=> core_hold_q && core_reset)
    else $error("core hold not set at release");
  core_only_a: assert property (core_hold_q && !ext_held |-> core_reset && !system_reset)
    else $error("core hold leaked to system");
  ext_held_a: assert property (ext_held && !$past(reset) |-> system_reset && slow_clock_select)
    else $error("internal reset or slow clock lost");
  slow_run_a: assert property (!$past(reset) |-> slow_clock_select)
    else $error("slow clock not selected");
  pin_reset_a: assert property (ext_assert |=> system_reset && core_reset)
    else $error("pin reset did not reach internal resets");
  hold_keep_a: assert property (core_hold_q && !ext_release && !wr_sys |=> core_hold_q)
    else $error("core hold dropped on its own");
  dbg_free_a: assert property (ext_held |-> !debug_port_reset)
    else $error("debug port held by pin reset");
  hold_clear_a: assert property (wr_sys && reg_wdata[erase_pkg::SYS_HOLD_CLR_BIT]
    && !ext_release && !ext_held |=> !core_hold_q)
    else $error("hold bit clear did not release core");
  prot_defer_a: assert property (protect_set_cmd && !ext_release && !eif.prot_clear
    |=> protected_state == $past(protected_state))
    else $error("protection took effect before reset");
  prot_pend_a: assert property (protect_set_cmd && !eif.prot_clear && !ext_release
    |=> prot_pend_q)
    else $error("protect command not held pending");
  tck_fall_a: assert property (tck_fall && !ext_held |=> test_port_enable)
    else $error("falling test clock did not enable port");
  tck_high_a: assert property (ext_release && tck_s |=> !test_port_enable)
    else $error("test port enabled with clock high");
  tp_off_held_a: assert property (ext_held |=> !test_port_enable)
    else $error("test port enabled during pin reset");

  erase_full_c: cover property (erase_go ##[1:50] $rose(eif.done));
  core_hold_c: cover property (ext_release && !tck_s ##[1:20] wr_sys);
  tp_enable_c: cover property (ext_release && tck_s ##[1:20] tck_fall);
  irq_done_c: cover property ($rose(irq) && irq_stat_q[erase_pkg::EV_DONE_BIT]);
  cmd_erase_c: cover property (wr_cmd && erase_go ##[1:50] $rose(eif.done));

endmodule

// ---- erase_pkg.sv ----
// Shared constants and types for the debug erase and core hold block
package erase_pkg;
  localparam logic [7:0]  CTRL_OFS     = 8'h00;
  localparam logic [7:0]  CMD_OFS      = 8'h04;
  localparam logic [7:0]  STATUS_OFS   = 8'h08;
  localparam logic [7:0]  SYSCTRL_OFS  = 8'h0c;
  localparam logic [7:0]  IRQ_STAT_OFS = 8'h10;
  localparam logic [7:0]  IRQ_MASK_OFS = 8'h14;
  localparam int          CTRL_CE_BIT  = 0;
  localparam int          SYS_HOLD_CLR_BIT = 0;
  localparam int          ST_DONE_BIT  = 0;
  localparam int          ST_HOLD_BIT  = 1;
  localparam int          ST_BUSY_BIT  = 2;
  localparam int          ST_PROT_BIT  = 3;
  localparam int          ST_TPEN_BIT  = 4;
  localparam int          ST_PEND_BIT  = 5;
  localparam int          IRQ_W        = 2;
  localparam int          EV_DONE_BIT  = 0;
  localparam int          EV_TPEN_BIT  = 1;
  localparam logic [7:0]  ERASE_CMD    = 8'h5a;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 2'h0;
  localparam logic [1:0]  PIN_SYNC_RST = 2'h2;
  typedef enum logic [2:0] {
    SEQ_IDLE  = 3'b000,
    SEQ_VOL   = 3'b001,
    SEQ_FLASH = 3'b010,
    SEQ_PROT  = 3'b011
  } seq_state_t;
endpackage

// ---- erase_if.sv ----
// Control link between register logic and the erase sequencer
interface erase_if;
  logic start;
  logic busy;
  logic done;
  logic prot_clear;
  modport seq (input start, output busy, output done, output prot_clear);
  modport ctl (output start, input busy, input done, input prot_clear);
endinterface

// ---- pin_sync.sv ----
// Two-stage synchroniser for asynchronous pin inputs
module pin_sync #(
  parameter int              WIDTH = 2,
  parameter logic [WIDTH-1:0] RST  = '0
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_s
);
  logic [WIDTH-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_q <= RST;
      pin_s  <= RST;
    end else begin
      meta_q <= pin_in;
      pin_s  <= meta_q;
    end
  end
endmodule

// ---- erase_seq.sv ----
// Chip erase sequencer: volatile memories, flash array, protected state
module erase_seq (
  input  wire logic clk,
  input  wire logic reset,
  erase_if.seq      ctl,
  input  wire logic volatile_clear_ack,
  input  wire logic flash_clear_ack,
  output logic      volatile_clear_req,
  output logic      flash_clear_req
);
  erase_pkg::seq_state_t state_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= erase_pkg::SEQ_IDLE;
    end else begin
      unique case (state_q)
        erase_pkg::SEQ_IDLE: begin
          if (ctl.start) begin
            state_q <= erase_pkg::SEQ_VOL;
          end
        end
        erase_pkg::SEQ_VOL: begin
          if (volatile_clear_ack) begin
            state_q <= erase_pkg::SEQ_FLASH;
          end
        end
        erase_pkg::SEQ_FLASH: begin
          if (flash_clear_ack) begin
            state_q <= erase_pkg::SEQ_PROT;
          end
        end
        erase_pkg::SEQ_PROT: begin
          state_q <= erase_pkg::SEQ_IDLE;
        end
        default: begin
          state_q <= erase_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  // Done drops at start and rises only once the last step is over
  always_ff @(posedge clk) begin
    if (reset) begin
      ctl.done <= 1'b0;
    end else if (state_q == erase_pkg::SEQ_IDLE && ctl.start) begin
      ctl.done <= 1'b0;
    end else if (state_q == erase_pkg::SEQ_PROT) begin
      ctl.done <= 1'b1;
    end
  end

  assign volatile_clear_req = (state_q == erase_pkg::SEQ_VOL);
  assign flash_clear_req    = (state_q == erase_pkg::SEQ_FLASH);
  assign ctl.prot_clear     = (state_q == erase_pkg::SEQ_PROT);
  assign ctl.busy           = (state_q != erase_pkg::SEQ_IDLE);
endmodule

// ---- debugger_model.sv ----
// Behavioural debugger driving the external reset and test clock pins
module debugger_model (
  input  wire logic clk,
  output logic      ext_reset_n_pin,
  output logic      test_clk_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // Power up with reset held and the test clock low
  initial begin
    ext_reset_n_pin = 1'b0;
    test_clk_pin = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Restart through the reset pin only; low tck stops the core before erase work
  task automatic restart(input logic tck_level);
    @(posedge clk);
    ext_reset_n_pin <= 1'b0;
    test_clk_pin <= tck_level;
    repeat (6) @(posedge clk);
    ext_reset_n_pin <= 1'b1;
    // Pin passes a 2-FF chain, so give it time to land
    repeat (6) @(posedge clk);
  endtask

  // Slow test clock pulse, ending on a falling edge
  task automatic tck_fall();
    @(posedge clk);
    test_clk_pin <= 1'b1;
    repeat (4) @(posedge clk);
    test_clk_pin <= 1'b0;
    repeat (5) @(posedge clk);
  endtask
endmodule

// ---- debug_chip_erase_core_hold_tb.sv ----
// Self-checking testbench for the debug erase and core hold block
module debug_chip_erase_core_hold_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        ext_reset_n_pin;
  logic        test_clk_pin;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        protect_set_cmd = 1'b0;
  logic        vol_ack = 1'b0;
  logic        flash_ack = 1'b0;
  logic        vol_req;
  logic        flash_req;
  logic        keep_page;
  logic        core_reset;
  logic        system_reset;
  logic        debug_port_reset;
  logic        slow_clock_select;
  logic        test_port_enable;
  logic        protected_state;
  logic        irq;
  int          err_total = 0;
  int          checks = 0;

  always #12.5 clk = ~clk;

  debugger_model i_dbg (
    .clk             (clk),
    .ext_reset_n_pin (ext_reset_n_pin),
    .test_clk_pin    (test_clk_pin)
  );

  debug_chip_erase_core_hold i_dut (
    .clk                  (clk),
    .reset                (reset),
    .ext_reset_n_pin      (ext_reset_n_pin),
    .test_clk_pin         (test_clk_pin),
    .reg_addr             (reg_addr),
    .reg_wdata            (reg_wdata),
    .reg_wr               (reg_wr),
    .reg_rd               (reg_rd),
    .reg_rdata            (reg_rdata),
    .protect_set_cmd      (protect_set_cmd),
    .volatile_clear_ack   (vol_ack),
    .flash_clear_ack      (flash_ack),
    .volatile_clear_req   (vol_req),
    .flash_clear_req      (flash_req),
    .flash_keep_user_page (keep_page),
    .core_reset           (core_reset),
    .system_reset         (system_reset),
    .debug_port_reset     (debug_port_reset),
    .slow_clock_select    (slow_clock_select),
    .test_port_enable     (test_port_enable),
    .protected_state      (protected_state),
    .irq                  (irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk1(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic s_power_up();
    logic [31:0] d;
    chk1(slow_clock_select, 1'b1);
    chk1(system_reset, 1'b1);
    chk1(debug_port_reset, 1'b0);
    i_dbg.restart(1'b0);
    #1;
    chk1(core_reset, 1'b1);
    chk1(system_reset, 1'b0);
    rd(erase_pkg::STATUS_OFS, d);
    chk1(d[erase_pkg::ST_HOLD_BIT], 1'b1);
    rd(8'h20, d);
    chk32(d, 32'h0);
  endtask

  // Masked event must not raise irq; status clears on read
  task automatic s_test_port();
    logic [31:0] d;
    chk1(test_port_enable, 1'b0);
    i_dbg.tck_fall();
    chk1(test_port_enable, 1'b1);
    chk1(irq, 1'b0);
    rd(erase_pkg::IRQ_STAT_OFS, d);
    chk32(d, 32'h2);
    rd(erase_pkg::IRQ_STAT_OFS, d);
    chk32(d, 32'h0);
  endtask

  task automatic s_protect();
    logic [31:0] d;
    @(posedge clk);
    protect_set_cmd <= 1'b1;
    @(posedge clk);
    protect_set_cmd <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk1(protected_state, 1'b0);
    rd(erase_pkg::STATUS_OFS, d);
    chk1(d[erase_pkg::ST_PEND_BIT], 1'b1);
    i_dbg.restart(1'b1);
    #1;
    chk1(protected_state, 1'b1);
    chk1(test_port_enable, 1'b0);
    chk1(core_reset, 1'b0);
  endtask

  task automatic s_hold_clear();
    logic [31:0] d;
    i_dbg.restart(1'b0);
    #1;
    chk1(core_reset, 1'b1);
    wr(erase_pkg::SYSCTRL_OFS, 32'h1);
    repeat (2) @(posedge clk);
    #1;
    chk1(core_reset, 1'b0);
    rd(erase_pkg::SYSCTRL_OFS, d);
    chk32(d, 32'h0);
    wr(erase_pkg::IRQ_MASK_OFS, 32'h1);
    rd(erase_pkg::IRQ_MASK_OFS, d);
    chk32(d, 32'h1);
  endtask

  // Slow acks from the memories; order and done flag checked throughout
  task automatic erase(input logic [7:0] a, input logic [31:0] v, input logic prot);
    logic [31:0] d;
    wr(a, v);
    #1;
    chk1(vol_req, 1'b1);
    chk1(flash_req, 1'b0);
    repeat (3) @(posedge clk);
    rd(erase_pkg::STATUS_OFS, d);
    chk32(d & 32'h5, 32'h4);
    @(posedge clk);
    vol_ack <= 1'b1;
    @(posedge clk);
    vol_ack <= 1'b0;
    #1;
    chk1(flash_req, 1'b1);
    chk1(vol_req, 1'b0);
    chk1(protected_state, prot);
    repeat (2) @(posedge clk);
    flash_ack <= 1'b1;
    @(posedge clk);
    flash_ack <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk1(protected_state, 1'b0);
    chk1(keep_page, 1'b1);
    chk1(irq, 1'b1);
    rd(erase_pkg::STATUS_OFS, d);
    chk32(d & 32'h5, 32'h1);
    rd(erase_pkg::IRQ_STAT_OFS, d);
    chk32(d, 32'h1);
    chk1(irq, 1'b0);
  endtask

  task automatic s_erase_cmd();
    wr(erase_pkg::CMD_OFS, 32'h0);
    repeat (2) @(posedge clk);
    #1;
    chk1(vol_req, 1'b0);
    erase(erase_pkg::CMD_OFS, {24'h0, erase_pkg::ERASE_CMD}, 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    end_of_test();
  end

  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    s_power_up();
    s_test_port();
    s_protect();
    s_hold_clear();
    i_dbg.restart(1'b0);
    erase(erase_pkg::CTRL_OFS, 32'h1, 1'b1);
    s_erase_cmd();
    end_of_test();
  end
endmodule
